// ===== rtl/chg_pkg.sv
// constants and carrier types for the charger mode and fault supervisor
// assumes a 25 MHz clock; analog comparators arrive as digital levels
package chg_pkg;
   localparam int unsigned CLK_HZ = 25000000;
   // times in their own units
   localparam int unsigned ALERT_PULSE_US = 128;
   localparam int unsigned MONITOR_MS = 2;
   localparam int unsigned HOST_READY_MS = 5;
   localparam int unsigned SC_DGL_US = 250;
   localparam int unsigned SC_REC_MS = 100;
   localparam int unsigned OVP_DGL_MS = 30;
   localparam int unsigned INPUT_UNDERVOLTAGE_FAULT_DGL_MS = 30;
   localparam int unsigned HYST_MV = 100;
   // cycle counts (least times round up)
   localparam int unsigned ALERT_CYC = (ALERT_PULSE_US * 25);
   localparam int unsigned MONITOR_CYC = (MONITOR_MS * 25000);
   localparam int unsigned HOST_READY_CYC = (HOST_READY_MS * 25000);
   localparam int unsigned SC_DGL_CYC = (SC_DGL_US * 25);
   localparam int unsigned SC_REC_CYC = (SC_REC_MS * 25000);
   localparam int unsigned OVP_DGL_CYC = (OVP_DGL_MS * 25000);
   localparam int unsigned INPUT_UNDERVOLTAGE_FAULT_DGL_CYC = (INPUT_UNDERVOLTAGE_FAULT_DGL_MS * 25000);
   localparam int CNT_W = 24;
   // droop threshold code: 0 = 4.2 V .. 7 = 4.9 V, 100 mV steps
   localparam logic [2:0] DROOP_CODE_MAX = 3'h7;
   // monitor level: 0 = below 60 %, 1..21 = 60 %..100 % in 2 % steps
   localparam logic [4:0] MON_LEVEL_MAX = 5'h15;
   localparam logic [4:0] MON_LEVEL_RST = 5'h00;

   typedef enum logic [2:0] {
      ST_HIZ, ST_BATTERY, ST_CHARGE, ST_DISABLED, ST_SLEEP,
      ST_OVERVOLT, ST_UNDERVOLT, ST_DONE
   } mode_t;

   // comparator levels from the analog front end
   typedef struct packed {
      logic in_above_uv;      // vin > undervoltage threshold
      logic in_above_sleep;   // vin > vbat + sleep margin
      logic in_overvolt;      // vin > overvoltage threshold
      logic bat_above_cutoff; // vbat > cutoff (falling)
      logic bat_above_hyst;   // vbat > cutoff + hysteresis
      logic bat_above_min;    // vbat > minimum cutoff
      logic short_limit;      // discharge short-circuit limit hit
      logic load_rail_ok;     // load rail at programmed level
      logic cv_loop;          // constant-voltage loop dominant
      logic other_loop;       // any non-cv loop dominant
      logic droop_loop;       // input droop loop active
      logic taper_current;    // current at taper stop level
      logic above_recharge;   // vbat above recharge level
   } sense_t;

   // fault flags, clear on host read once cause is gone
   typedef struct packed {
      logic sleep;
      logic overvolt;
      logic undervolt;
   } fault_t;
endpackage : chg_pkg

// ===== rtl/chg_supervisor.sv
// mode sequencer, fet enables, alert pulse, fault flags, battery monitor
// assumes sense inputs already synchronous to clk; host side is pins only
`timescale 1ns/1ns
module chg_supervisor
(
   input  wire logic            clk,
   input  wire logic            reset,
   input  wire chg_pkg::sense_t sense,
   input  wire logic            charge_disable_pin,
   input  wire logic            charge_enable_n,
   input  wire logic            droop_enable,
   input  wire logic [2:0]      droop_code,
   input  wire logic            half_speed_safety_timer,
   input  wire logic            battery_monitor_trigger,
   input  wire logic [4:0]      battery_monitor_adc,
   input  wire logic            fault_read,
   output logic                 bat_fet_on,
   output logic                 supplement_fet_on,
   output logic                 charge_fet_on,
   output logic                 alert_pulse,
   output chg_pkg::fault_t      fault_flags,
   output logic                 input_droop_flag,
   output logic                 safety_timer_half,
   output logic                 host_if_active,
   output logic [2:0]           droop_threshold,
   output logic [4:0]           battery_monitor_level,
   output logic                 battery_monitor_valid,
   output chg_pkg::mode_t       mode
);
   chg_pkg::mode_t      mode_r, mode_nxt;
   chg_pkg::fault_t     flt_r, flt_set, flt_active;
   logic [chg_pkg::CNT_W-1:0] sc_cnt_r, ov_cnt_r, uv_cnt_r, mon_cnt_r;
   logic [chg_pkg::CNT_W-1:0] al_cnt_r, rdy_cnt_r;
   logic                 sc_off_r, sc_rec_r, ov_r, uv_r, cut_r;
   logic                 mon_busy_r, mon_valid_r, rdy_r, droop_r;
   logic [4:0]           mon_lvl_r;
   logic                 in_valid, chg_allowed, term_ok, sc_trip, sc_done;
   logic                 ov_dgl_done, uv_dgl_done, mon_start, mon_done;
   logic                 enter_fault, ov_fault, droop_now;

   // short counter: deglitch while tripped, recovery while off
   assign sc_trip  = !sc_rec_r && sense.short_limit
                     && sc_cnt_r == chg_pkg::CNT_W'(chg_pkg::SC_DGL_CYC - 1);
   assign sc_done  = sc_rec_r
                     && sc_cnt_r == chg_pkg::CNT_W'(chg_pkg::SC_REC_CYC - 1);
   assign ov_dgl_done = ov_cnt_r == chg_pkg::CNT_W'(chg_pkg::OVP_DGL_CYC);
   assign uv_dgl_done = uv_cnt_r == chg_pkg::CNT_W'(chg_pkg::INPUT_UNDERVOLTAGE_FAULT_DGL_CYC);
   assign in_valid = !uv_r && !ov_r && sense.in_above_sleep;
   assign chg_allowed = in_valid && !charge_disable_pin
                        && !charge_enable_n;
   // live droop level: the registered flag lags one edge behind the loop
   assign droop_now = droop_enable && sense.droop_loop;
   assign term_ok = sense.cv_loop && !sense.other_loop
                    && !droop_now;
   // fault entry events raise the alert once per entry
   assign ov_fault = sense.in_overvolt && !ov_r;
   assign flt_active = '{sleep: mode_r == chg_pkg::ST_SLEEP,
                         overvolt: ov_r, undervolt: uv_r};
   assign flt_set = '{sleep: mode_nxt == chg_pkg::ST_SLEEP
                             && mode_r != chg_pkg::ST_SLEEP,
                      overvolt: ov_fault,
                      undervolt: uv_dgl_done && !uv_r};
   assign enter_fault = |flt_set;
   // monitor: host trigger, or automatically on the edge that enters high impedance
   assign mon_start = !mon_busy_r && (battery_monitor_trigger
      || (mode_nxt == chg_pkg::ST_HIZ && mode_r != chg_pkg::ST_HIZ));
   assign mon_done = mon_busy_r
      && mon_cnt_r == chg_pkg::CNT_W'(chg_pkg::MONITOR_CYC - 1);

   always_comb
   begin
      mode_nxt = mode_r;
      unique case (mode_r)
         chg_pkg::ST_HIZ, chg_pkg::ST_BATTERY:
         begin
            if (sense.in_above_uv && !uv_r)
               mode_nxt = chg_allowed ? chg_pkg::ST_CHARGE
                                      : chg_pkg::ST_DISABLED;
            else
               mode_nxt = charge_disable_pin ? chg_pkg::ST_BATTERY
                                             : chg_pkg::ST_HIZ;
         end
         chg_pkg::ST_CHARGE:
         begin
            if (!chg_allowed)
               mode_nxt = chg_pkg::ST_DISABLED;
            else if (term_ok && sense.taper_current
                     && sense.above_recharge)
               mode_nxt = chg_pkg::ST_DONE;
         end
         chg_pkg::ST_DISABLED, chg_pkg::ST_DONE:
         begin
            if (mode_r == chg_pkg::ST_DISABLED && chg_allowed)
               mode_nxt = chg_pkg::ST_CHARGE;
            else if (mode_r == chg_pkg::ST_DONE && !chg_allowed)
               mode_nxt = chg_pkg::ST_DISABLED;
         end
         chg_pkg::ST_SLEEP:
            if (sense.in_above_sleep)
               mode_nxt = chg_pkg::ST_CHARGE;
         chg_pkg::ST_OVERVOLT:
            if (ov_dgl_done)
               mode_nxt = chg_pkg::ST_DISABLED;
         chg_pkg::ST_UNDERVOLT:
            mode_nxt = charge_disable_pin ? chg_pkg::ST_BATTERY
                                          : chg_pkg::ST_HIZ;
      endcase
      // faults take priority over normal sequencing
      if (ov_fault || (ov_r && mode_r != chg_pkg::ST_OVERVOLT))
         mode_nxt = chg_pkg::ST_OVERVOLT;
      else if (uv_dgl_done && !uv_r)
         mode_nxt = chg_pkg::ST_UNDERVOLT;
      else if (!uv_r && !ov_r && sense.in_above_uv
               && !sense.in_above_sleep
               && mode_r != chg_pkg::ST_HIZ
               && mode_r != chg_pkg::ST_BATTERY)
         mode_nxt = chg_pkg::ST_SLEEP;
      // leaving DISABLED picks CHARGE via chg_allowed, so SLEEP goes there
      if (mode_r == chg_pkg::ST_SLEEP && mode_nxt == chg_pkg::ST_CHARGE
          && !chg_allowed)
         mode_nxt = chg_pkg::ST_DISABLED;
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         mode_r <= chg_pkg::ST_HIZ;
         {sc_cnt_r, ov_cnt_r, uv_cnt_r} <= '0;
         {sc_off_r, sc_rec_r, ov_r, uv_r, cut_r} <= '0;
      end
      else
      begin
         mode_r <= mode_nxt;
         if (sc_trip || sc_done)
            sc_cnt_r <= '0;
         else if (sc_rec_r || sense.short_limit)
            sc_cnt_r <= sc_cnt_r + 1'b1;
         else
            sc_cnt_r <= '0;
         if (sc_trip)
            sc_rec_r <= 1'b1;
         else if (sc_done)
            sc_rec_r <= 1'b0;
         // overvoltage asserts at once, release is deglitched
         if (sense.in_overvolt)
            ov_r <= 1'b1;
         else if (ov_dgl_done)
            ov_r <= 1'b0;
         ov_cnt_r <= (ov_r && !sense.in_overvolt && !ov_dgl_done)
                     ? ov_cnt_r + 1'b1 : '0;
         // undervoltage asserts after deglitch, releases at once
         uv_cnt_r <= (!sense.in_above_uv && !uv_r && !uv_dgl_done)
                     ? uv_cnt_r + 1'b1 : '0;
         if (uv_dgl_done)
            uv_r <= 1'b1;
         else if (sense.in_above_uv)
            uv_r <= 1'b0;
         // cutoff with 100 mV hysteresis on recovery
         if (!sense.bat_above_cutoff)
            cut_r <= 1'b1;
         else if (sense.bat_above_hyst)
            cut_r <= 1'b0;
      end
   end

   // set wins over read clear; clear needs the cause gone
   always_ff @(posedge clk)
   begin
      if (reset)
         flt_r <= '0;
      else
         flt_r <= flt_set | (flt_r & ~(fault_read ? ~flt_active
                                                 : 3'h0));
   end

   // alert pulse, restarted by each fault entry
   always_ff @(posedge clk)
   begin
      if (reset)
         al_cnt_r <= '0;
      else if (enter_fault)
         al_cnt_r <= chg_pkg::CNT_W'(chg_pkg::ALERT_CYC);
      else if (al_cnt_r != '0)
         al_cnt_r <= al_cnt_r - 1'b1;
   end

   // host interfaces wake a fixed delay after the load rail settles
   always_ff @(posedge clk)
   begin
      if (reset || !sense.load_rail_ok)
      begin
         rdy_cnt_r <= '0;
         rdy_r <= 1'b0;
      end
      else if (rdy_cnt_r == chg_pkg::CNT_W'(chg_pkg::HOST_READY_CYC - 1))
         rdy_r <= 1'b1;
      else
         rdy_cnt_r <= rdy_cnt_r + 1'b1;
   end

   // monitor: result latched at end of conversion; codes above 21 clamp to 100 %
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         mon_busy_r <= 1'b0;
         mon_valid_r <= 1'b0;
         mon_cnt_r <= '0;
         mon_lvl_r <= chg_pkg::MON_LEVEL_RST;
         droop_r <= 1'b0;
      end
      else
      begin
         droop_r <= droop_enable && sense.droop_loop;
         if (mon_start)
         begin
            mon_busy_r <= 1'b1;
            mon_valid_r <= 1'b0;
            mon_cnt_r <= '0;
         end
         else if (mon_done)
         begin
            mon_busy_r <= 1'b0;
            mon_valid_r <= 1'b1;
            mon_lvl_r <= (battery_monitor_adc > chg_pkg::MON_LEVEL_MAX)
                         ? chg_pkg::MON_LEVEL_MAX
                         : battery_monitor_adc;
         end
         else if (mon_busy_r)
            mon_cnt_r <= mon_cnt_r + 1'b1;
      end
   end

   // fet enables; sleep and overvoltage run the load from battery
   assign bat_fet_on = !sc_rec_r && !cut_r
      && (mode_r == chg_pkg::ST_BATTERY || mode_r == chg_pkg::ST_SLEEP
          || mode_r == chg_pkg::ST_OVERVOLT || mode_r == chg_pkg::ST_CHARGE
          || (mode_r == chg_pkg::ST_DISABLED && sense.bat_above_min
              && charge_enable_n == 1'b0));
   assign supplement_fet_on = !sc_rec_r && sense.bat_above_min
      && sense.in_above_uv && !uv_r
      && mode_r != chg_pkg::ST_HIZ;
   assign charge_fet_on = mode_r == chg_pkg::ST_CHARGE && !sc_rec_r;
   assign alert_pulse = al_cnt_r != '0;
   assign fault_flags = flt_r;
   assign input_droop_flag = droop_r;
   assign safety_timer_half = half_speed_safety_timer && droop_r;
   assign host_if_active = rdy_r;
   assign droop_threshold = droop_code & chg_pkg::DROOP_CODE_MAX;
   assign battery_monitor_level = mon_lvl_r;
   assign battery_monitor_valid = mon_valid_r;
   assign mode = mode_r;

   a_alert_width: assert property (@(posedge clk) disable iff (reset)
      $rose(alert_pulse) |-> alert_pulse [*8])
      else $error("alert pulse too short");
   a_done_on_taper: assert property (@(posedge clk) disable iff (reset)
      (mode_r == chg_pkg::ST_CHARGE && mode_nxt == chg_pkg::ST_DONE)
      |-> term_ok) else $error("termination while not cv");
   a_no_term_droop: assert property (@(posedge clk) disable iff (reset)
      droop_now |-> mode_nxt != chg_pkg::ST_DONE || mode_r == mode_nxt)
      else $error("termination during droop");
   a_charge_gated: assert property (@(posedge clk) disable iff (reset)
      charge_fet_on |-> !$past(charge_disable_pin)
                        && !$past(charge_enable_n))
      else $error("charging with pin high");
   a_short_off: assert property (@(posedge clk) disable iff (reset)
      sc_trip |=> !bat_fet_on [*8])
      else $error("fet on during recovery");
   a_sleep_flag: assert property (@(posedge clk) disable iff (reset)
      flt_set.sleep |=> fault_flags.sleep && alert_pulse)
      else $error("sleep entry not flagged");
   a_flag_hold: assert property (@(posedge clk) disable iff (reset)
      (fault_flags.overvolt && ov_r) |=> fault_flags.overvolt)
      else $error("ov flag cleared too early");
   a_monitor_delay: assert property (@(posedge clk) disable iff (reset)
      mon_start |=> !mon_valid_r [*8])
      else $error("monitor valid too soon");
   a_cutoff_off: assert property (@(posedge clk) disable iff (reset)
      !sense.bat_above_cutoff |=> !bat_fet_on)
      else $error("fet on below cutoff");
endmodule : chg_supervisor

// ===== test/host_model.sv
// host processor model: charge-disable pin, fault reads, monitor trigger
// assumes the bench calls its tasks from one sequence, one at a time
`timescale 1ns/1ns
module host_model
(
   input  wire logic clk,
   output logic      charge_disable_pin,
   output logic      battery_monitor_trigger,
   output logic      fault_read
);
   // pin idles low like the internal pull-down
   initial
   begin
      charge_disable_pin      = 1'b0;
      battery_monitor_trigger = 1'b0;
      fault_read              = 1'b0;
   end

   task automatic set_pin(input logic v);
      @(posedge clk);
      #1 charge_disable_pin = v;
   endtask : set_pin

   // one-cycle strobes, changed just after an edge
   task automatic read_faults;
      @(posedge clk);
      #1 fault_read = 1'b1;
      @(posedge clk);
      #1 fault_read = 1'b0;
   endtask : read_faults

   task automatic start_monitor;
      @(posedge clk);
      #1 battery_monitor_trigger = 1'b1;
      @(posedge clk);
      #1 battery_monitor_trigger = 1'b0;
   endtask : start_monitor
endmodule : host_model

// ===== test/tb_chg_supervisor.sv
// self-checking bench for the charger mode and fault supervisor
// assumes 25 MHz clk, sync reset, comparator levels driven as plain bits
`timescale 1ns/1ns
module tb_chg_supervisor;
   logic            clk = 1'b0;
   logic            reset;
   chg_pkg::sense_t sense;
   logic            charge_disable_pin, battery_monitor_trigger, fault_read;
   logic            charge_enable_n;
   logic            droop_enable;
   logic [2:0]      droop_code;
   logic            half_speed_safety_timer;
   logic [4:0]      battery_monitor_adc;
   logic            bat_fet_on, supplement_fet_on, charge_fet_on;
   logic            alert_pulse, input_droop_flag, safety_timer_half;
   logic            host_if_active, battery_monitor_valid;
   chg_pkg::fault_t fault_flags;
   logic [2:0]      droop_threshold;
   logic [4:0]      battery_monitor_level;
   chg_pkg::mode_t  mode;
   int              bad_count = 0;
   int              checked = 0;

   always #20 clk = ~clk;

   chg_supervisor u_dut (.clk(clk), .reset(reset), .sense(sense),
      .charge_disable_pin(charge_disable_pin),
      .charge_enable_n(charge_enable_n), .droop_enable(droop_enable),
      .droop_code(droop_code),
      .half_speed_safety_timer(half_speed_safety_timer),
      .battery_monitor_trigger(battery_monitor_trigger),
      .battery_monitor_adc(battery_monitor_adc), .fault_read(fault_read),
      .bat_fet_on(bat_fet_on), .supplement_fet_on(supplement_fet_on),
      .charge_fet_on(charge_fet_on), .alert_pulse(alert_pulse),
      .fault_flags(fault_flags), .input_droop_flag(input_droop_flag),
      .safety_timer_half(safety_timer_half),
      .host_if_active(host_if_active), .droop_threshold(droop_threshold),
      .battery_monitor_level(battery_monitor_level),
      .battery_monitor_valid(battery_monitor_valid), .mode(mode));

   host_model u_host (.clk(clk), .charge_disable_pin(charge_disable_pin),
      .battery_monitor_trigger(battery_monitor_trigger),
      .fault_read(fault_read));

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : cyc

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp)
      begin
         bad_count++;
         $display("Error at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask : chk

   task automatic wrap_up;
      $display("checks %0d errors %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : wrap_up

   // battery present and healthy, no input, rail up
   task automatic do_reset;
      reset = 1'b1;
      sense = 13'h0000;
      charge_enable_n = 1'b1;
      droop_enable = 1'b0;
      droop_code = 3'h0;
      half_speed_safety_timer = 1'b0;
      battery_monitor_adc = 5'h15;
      sense.bat_above_cutoff = 1'b1;
      sense.bat_above_hyst = 1'b1;
      sense.bat_above_min = 1'b1;
      sense.load_rail_ok = 1'b1;
      cyc(16);
      reset = 1'b0;
      cyc(1);
      chk(8'(mode), 8'(chg_pkg::ST_HIZ));
      chk(8'(fault_flags), 8'h00);
      chk(8'(alert_pulse), 8'h00);
      chk(8'(battery_monitor_level), 8'(chg_pkg::MON_LEVEL_RST));
      chk(8'(battery_monitor_valid), 8'h00);
      chk(8'(host_if_active), 8'h00);
   endtask : do_reset

   task automatic t_battery;
      u_host.set_pin(1'b1);
      cyc(4);
      chk(8'(mode), 8'(chg_pkg::ST_BATTERY));
      chk(8'(bat_fet_on), 8'h01);
      sense.bat_above_cutoff = 1'b0;
      sense.bat_above_hyst = 1'b0;
      cyc(4);
      chk(8'(bat_fet_on), 8'h00);
      // inside the hysteresis band the fet must stay off
      sense.bat_above_cutoff = 1'b1;
      cyc(4);
      chk(8'(bat_fet_on), 8'h00);
      sense.bat_above_hyst = 1'b1;
      cyc(4);
      chk(8'(bat_fet_on), 8'h01);
      sense.in_above_uv = 1'b1;
      sense.in_above_sleep = 1'b1;
      cyc(4);
      chk(8'(supplement_fet_on), 8'h01);
      chk(8'(charge_fet_on), 8'h00);
   endtask : t_battery

   task automatic t_charge;
      u_host.set_pin(1'b0);
      cyc(4);
      chk(8'(charge_fet_on), 8'h00);
      charge_enable_n = 1'b0;
      cyc(4);
      chk(8'(mode), 8'(chg_pkg::ST_CHARGE));
      chk(8'(charge_fet_on), 8'h01);
      u_host.set_pin(1'b1);
      cyc(4);
      chk(8'(charge_fet_on), 8'h00);
      u_host.set_pin(1'b0);
      cyc(4);
      chk(8'(charge_fet_on), 8'h01);
   endtask : t_charge

   task automatic t_taper;
      // droop loop switched off: no flag
      sense.droop_loop = 1'b1;
      cyc(2);
      chk(8'(input_droop_flag), 8'h00);
      droop_enable = 1'b1;
      droop_code = 3'h3;
      half_speed_safety_timer = 1'b1;
      sense.cv_loop = 1'b1;
      sense.taper_current = 1'b1;
      sense.above_recharge = 1'b1;
      cyc(4);
      chk(8'(droop_threshold), 8'h03);
      chk(8'(input_droop_flag), 8'h01);
      chk(8'(safety_timer_half), 8'h01);
      chk(8'(mode), 8'(chg_pkg::ST_CHARGE));
      sense.droop_loop = 1'b0;
      sense.other_loop = 1'b1;
      cyc(4);
      chk(8'(mode), 8'(chg_pkg::ST_CHARGE));
      chk(8'(input_droop_flag), 8'h00);
      sense.other_loop = 1'b0;
      cyc(4);
      chk(8'(mode), 8'(chg_pkg::ST_DONE));
      chk(8'(charge_fet_on), 8'h00);
   endtask : t_taper

   task automatic t_sleep;
      sense.in_above_sleep = 1'b0;
      cyc(1);
      chk(8'(mode), 8'(chg_pkg::ST_SLEEP));
      chk(8'(alert_pulse), 8'h01);
      chk(8'(fault_flags.sleep), 8'h01);
      chk(8'(bat_fet_on), 8'h01);
      u_host.read_faults();
      chk(8'(fault_flags.sleep), 8'h01);
      sense.taper_current = 1'b0;
      sense.in_above_sleep = 1'b1;
      cyc(4);
      chk(8'(mode), 8'(chg_pkg::ST_CHARGE));
      // let the pulse expire so the next fault gives a fresh edge
      cyc(3300);
      chk(8'(alert_pulse), 8'h00);
      u_host.read_faults();
      cyc(1);
      chk(8'(fault_flags.sleep), 8'h00);
   endtask : t_sleep

   task automatic t_monitor;
      u_host.set_pin(1'b1);
      // out-of-range code must clamp to the top level
      battery_monitor_adc = 5'h1F;
      u_host.start_monitor();
      chk(8'(battery_monitor_valid), 8'h00);
      cyc(49999);
      chk(8'(battery_monitor_valid), 8'h00);
      cyc(1);
      chk(8'(battery_monitor_valid), 8'h01);
      chk(8'(battery_monitor_level), 8'(chg_pkg::MON_LEVEL_MAX));
      u_host.set_pin(1'b0);
   endtask : t_monitor

   task automatic t_overvolt;
      sense.in_overvolt = 1'b1;
      cyc(1);
      chk(8'(mode), 8'(chg_pkg::ST_OVERVOLT));
      chk(8'(fault_flags.overvolt), 8'h01);
      chk(8'(alert_pulse), 8'h01);
      chk(8'(bat_fet_on), 8'h01);
      cyc(chg_pkg::ALERT_CYC - 1);
      chk(8'(alert_pulse), 8'h01);
      cyc(1);
      chk(8'(alert_pulse), 8'h00);
      u_host.read_faults();
      chk(8'(fault_flags.overvolt), 8'h01);
      sense.in_overvolt = 1'b0;
      cyc(4);
      chk(8'(mode), 8'(chg_pkg::ST_OVERVOLT));
   endtask : t_overvolt

   // recovery lasts far longer than the run, so only the trip is seen
   task automatic t_short;
      do_reset();
      u_host.set_pin(1'b1);
      cyc(4);
      sense.short_limit = 1'b1;
      cyc(chg_pkg::SC_DGL_CYC - 8);
      chk(8'(bat_fet_on), 8'h01);
      cyc(16);
      chk(8'(bat_fet_on), 8'h00);
   endtask : t_short

   initial
   begin
      do_reset();
      t_battery();
      t_charge();
      t_taper();
      t_sleep();
      t_monitor();
      t_overvolt();
      t_short();
      wrap_up();
   end

   // about 64k cycles expected; cut off at 100k
   initial
   begin
      #4000000;
      bad_count++;
      wrap_up();
   end
endmodule : tb_chg_supervisor
